//--- inc/pcr_pkg.sv
/*
  Package of the path and channel route decoder: node kinds, decoder
  states, address byte layout, error codes and reset values.
  Assumes a SystemVerilog tool; nothing here is imported anywhere.
*/
package pcr_pkg;

  // ****************************************************************
  // address byte layout
  // ****************************************************************
  localparam int          EXTEND_BIT    = 7;      // continuation flag
  localparam int          INDEX_MSB     = 6;      // top of hop-count field
  localparam int          INDEX_WIDTH   = 7;
  localparam logic [7:0]  BYTE_ACCEPT   = 8'h00;  // addressed to this node
  localparam logic [7:0]  BYTE_BAD      = 8'h80;  // zero index, extended

  // ****************************************************************
  // channel numbering
  // ****************************************************************
  localparam int           CHAN_WIDTH   = 14;
  localparam logic [13:0]  CHAN_TWO_MIN = 14'h0081; // least two-byte channel

  // ****************************************************************
  // ports, errors and reset values
  // ****************************************************************
  localparam int          PORT_WIDTH    = 7;
  localparam logic [6:0]  PORT_ONE      = 7'h01;
  localparam logic [6:0]  PORT_TWO      = 7'h02;
  localparam int          PORTS_MIN     = 4;
  localparam int          PORTS_MAX     = 126;
  localparam int          CODE_WIDTH    = 4;
  localparam logic [3:0]  CODE_NONE     = 4'h0;
  localparam logic [3:0]  CODE_FRAME_REJECT = 4'h9;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [6:0]  RESET_PORT    = 7'h00;
  localparam logic [13:0] RESET_CHAN    = 14'h0000;

  // ****************************************************************
  // node kinds and decoder states
  // ****************************************************************
  typedef enum logic [1:0] {
    NODE_SINGLE = 2'h0,
    NODE_DUAL   = 2'h1,
    NODE_SWITCH = 2'h2
  } pcr_node_type;

  typedef enum logic [1:0] {
    ST_PATH,
    ST_CHAN1,
    ST_CHAN2,
    ST_DONE
  } pcr_state_type;

endpackage

//--- core/pcr_route_decoder.sv
/*
  Route decoder for inbound frames: reads the address bytes of one
  frame, one byte per enabled cycle, and decides to accept the frame
  (with its channel number), forward it (with output port and the new
  first path byte) or reject it and invoke link error recovery.
  Assumes the receiver marks each frame with frameStart, presents the
  address bytes in order with byteValid, and marks the end with
  frameEnd. All inputs except resetn, which is asynchronous, are synchronous to sys_clk.
*/
// Function
// - invalid path raises recovery with frame-reject code
// - single port accepts 00h, then decodes channel
// - single port rejects nonzero first path byte
// - single port always reports port one
// - dual accepts 00h, else decrements a nonzero index and forwards
// - dual port rejects first byte 80h
// - dual port reports port one or two
// - switch has even port count 4 to 126
// - switch accepts zero first byte from any port
// - direct scheme forwards to indexed port, deletes byte
// - index above port count forwards to paired port
// - paired scheme keeps byte, subtracts ports plus one
// - switch rejects first byte 80h
// - switch rejects direct index with flag clear
// - switch rejects direct index equal to input port
// - order: accept, paired, rejects, direct forward
// - switch ports numbered one through port count
// - one-byte channels 0-127, two-byte 129-16383
// - channel byte 80h or malformed selector rejects
// - set flag continues component, clear flag ends
// - hop-count field is seven-bit unsigned

`timescale 1ns/1ps
`default_nettype none

module pcr_route_decoder #(
  parameter int PORT_COUNT = 4    // switch port count
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // configuration
  input  wire logic [1:0]  nodeKind,
  input  wire logic [6:0]  inPort,
  // address byte stream from the port receiver
  input  wire logic        frameStart,
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  input  wire logic        frameEnd,
  // internal acceptance
  output logic             acceptValid,
  output logic [13:0]      channelNum,
  // forwarding
  output logic             forwardValid,
  output logic [6:0]       outPort,
  output logic [7:0]       hopByte,
  output logic             deleteHop,
  // rejection and link error recovery
  output logic             rejectValid,
  output logic             link_error_recovery,
  output logic [3:0]       recvErrorCode,
  // port number for error reporting
  output logic [6:0]       reportPort
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************

  // switch port count must be even and within range
  if ((PORT_COUNT < pcr_pkg::PORTS_MIN) ||
      (PORT_COUNT > pcr_pkg::PORTS_MAX) ||
      (PORT_COUNT % 2 != 0)) begin : gen_bad_ports
    $error("port count must be even and from 4 through 126");
  end

  localparam logic [6:0] PORTS    = 7'(PORT_COUNT);
  localparam logic [6:0] PORTS_P1 = 7'(PORT_COUNT + 1);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // partner of a port in the odd/even pairing
  function automatic logic [6:0] pairedPort(input logic [6:0] p);
    pairedPort = p[0] ? 7'(p + 7'h01) : 7'(p - 7'h01);
  endfunction

  // continuation flag of an address byte
  function automatic logic extendOf(input logic [7:0] b);
    extendOf = b[pcr_pkg::EXTEND_BIT];
  endfunction

  // hop-count field of an address byte
  function automatic logic [6:0] indexOf(input logic [7:0] b);
    indexOf = b[pcr_pkg::INDEX_MSB:0];
  endfunction

  // ****************************************************************
  // path decision for the first path byte
  // ****************************************************************

  logic       pathAccept;
  logic       pathForward;
  logic       pathReject;
  logic [6:0] fwdPort;
  logic [7:0] fwdByte;
  logic       fwdDelete;
  logic [6:0] byteIndex;

  assign byteIndex = indexOf(byteData);

  // decide per node kind what the first path byte means
  always_comb begin
    pathAccept  = 1'b0;
    pathForward = 1'b0;
    pathReject  = 1'b0;
    fwdPort     = pcr_pkg::RESET_PORT;
    fwdByte     = byteData;
    fwdDelete   = 1'b0;
    unique case (pcr_pkg::pcr_node_type'(nodeKind))
      pcr_pkg::NODE_SINGLE: begin
        if (byteData == pcr_pkg::BYTE_ACCEPT) begin
          pathAccept = 1'b1;
        end else begin
          pathReject = 1'b1;
        end
      end
      pcr_pkg::NODE_DUAL: begin
        if (byteData == pcr_pkg::BYTE_ACCEPT) begin
          pathAccept = 1'b1;
        end else if (byteIndex != 7'h00) begin
          pathForward = 1'b1;
          fwdByte = {extendOf(byteData), 7'(byteIndex - 7'h01)};
          fwdPort = (inPort == pcr_pkg::PORT_ONE) ?
                    pcr_pkg::PORT_TWO : pcr_pkg::PORT_ONE;
        end else begin
          pathReject = 1'b1;
        end
      end
      pcr_pkg::NODE_SWITCH: begin
        // tested strictly in this order
        if (byteData == pcr_pkg::BYTE_ACCEPT) begin
          pathAccept = 1'b1;
        end else if (byteIndex > PORTS) begin
          pathForward = 1'b1;
          fwdPort = pairedPort(inPort);
          fwdByte = {extendOf(byteData),
                     7'(byteIndex - PORTS_P1)};
        end else if (byteData == pcr_pkg::BYTE_BAD) begin
          pathReject = 1'b1;
        end else if (!extendOf(byteData)) begin
          pathReject = 1'b1;
        end else if (byteIndex == inPort) begin
          pathReject = 1'b1;
        end else begin
          pathForward = 1'b1;
          fwdPort   = byteIndex;
          fwdDelete = 1'b1;
        end
      end
      default: begin
        pathReject = 1'b1;  // unused node code: nothing is valid
      end
    endcase
  end

  // ****************************************************************
  // decoder state
  // ****************************************************************

  pcr_pkg::pcr_state_type stateReg;
  pcr_pkg::pcr_state_type stateNext;
  logic [6:0]             chanHighReg;
  logic                   takeByte;
  logic                   chanOk1;
  logic                   chanOk2;
  logic                   chanEnd1;
  logic [13:0]            chanTwo;

  // a start resets the walk and its byte counts as the first one
  assign takeByte = byteValid;

  // one-byte channel: 80h is malformed, flag clear ends selector
  assign chanEnd1 = !extendOf(byteData);
  assign chanOk1  = (byteData != pcr_pkg::BYTE_BAD);

  // two-byte channel number and its validity
  assign chanTwo = {chanHighReg, byteIndex};
  assign chanOk2 = !extendOf(byteData) &&
                   (chanTwo >= pcr_pkg::CHAN_TWO_MIN);

  // next state of the address walk
  always_comb begin
    stateNext = stateReg;
    if (frameStart) begin
      stateNext = pcr_pkg::ST_PATH;
    end
    unique case (frameStart ? pcr_pkg::ST_PATH : stateReg)
      pcr_pkg::ST_PATH: begin
        if (takeByte) begin
          stateNext = pathAccept ? pcr_pkg::ST_CHAN1 : pcr_pkg::ST_DONE;
        end
      end
      pcr_pkg::ST_CHAN1: begin
        if (takeByte) begin
          stateNext = (chanOk1 && !chanEnd1) ?
                      pcr_pkg::ST_CHAN2 : pcr_pkg::ST_DONE;
        end else if (frameEnd) begin
          stateNext = pcr_pkg::ST_DONE;
        end
      end
      pcr_pkg::ST_CHAN2: begin
        if (takeByte || frameEnd) begin
          stateNext = pcr_pkg::ST_DONE;
        end
      end
      pcr_pkg::ST_DONE: begin
        stateNext = pcr_pkg::ST_DONE;
      end
    endcase
  end

  // state register; done holds until the next frame start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= pcr_pkg::ST_DONE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ****************************************************************
  // events of this cycle
  // ****************************************************************

  pcr_pkg::pcr_state_type stateNow;
  logic                   evAccept;
  logic                   evForward;
  logic                   evReject;
  logic [13:0]            evChan;

  assign stateNow = frameStart ? pcr_pkg::ST_PATH : stateReg;

  // classify the byte against the walk position
  always_comb begin
    evAccept  = 1'b0;
    evForward = 1'b0;
    evReject  = 1'b0;
    evChan    = pcr_pkg::RESET_CHAN;
    unique case (stateNow)
      pcr_pkg::ST_PATH: begin
        evForward = takeByte && pathForward;
        evReject  = takeByte && pathReject;
      end
      pcr_pkg::ST_CHAN1: begin
        if (takeByte) begin
          if (!chanOk1) begin
            evReject = 1'b1;
          end else if (chanEnd1) begin
            evAccept = 1'b1;
            evChan   = {7'h00, byteIndex};
          end
        end else if (frameEnd) begin
          evReject = 1'b1;  // frame ended without a channel
        end
      end
      pcr_pkg::ST_CHAN2: begin
        if (takeByte) begin
          evAccept = chanOk2;
          evReject = !chanOk2;
          evChan   = chanTwo;
        end else if (frameEnd) begin
          evReject = 1'b1;  // two-byte selector cut short
        end
      end
      pcr_pkg::ST_DONE: begin
        evAccept = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // registered results
  // ****************************************************************

  // high half of a two-byte channel selector
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chanHighReg <= 7'h00;
    end else if (stateNow == pcr_pkg::ST_CHAN1 && takeByte) begin
      chanHighReg <= byteIndex;
    end
  end

  // acceptance pulse and channel number
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acceptValid <= 1'b0;
      channelNum  <= pcr_pkg::RESET_CHAN;
    end else begin
      acceptValid <= evAccept;
      if (evAccept) begin
        channelNum <= evChan;
      end
    end
  end

  // forwarding pulse with port and rewritten first byte
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      forwardValid <= 1'b0;
      outPort      <= pcr_pkg::RESET_PORT;
      hopByte      <= pcr_pkg::RESET_BYTE;
      deleteHop    <= 1'b0;
    end else begin
      forwardValid <= evForward;
      if (evForward) begin
        outPort   <= fwdPort;
        hopByte   <= fwdByte;
        deleteHop <= fwdDelete;
      end
    end
  end

  // rejection pulse and recovery invocation with its code
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rejectValid         <= 1'b0;
      link_error_recovery <= 1'b0;
      recvErrorCode       <= pcr_pkg::CODE_NONE;
    end else begin
      rejectValid         <= evReject;
      link_error_recovery <= evReject;
      if (evReject) begin
        recvErrorCode <= pcr_pkg::CODE_FRAME_REJECT;
      end
    end
  end

  // port number for error reporting and configuration
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reportPort <= pcr_pkg::PORT_ONE;
    end else begin
      unique case (pcr_pkg::pcr_node_type'(nodeKind))
        pcr_pkg::NODE_SINGLE: reportPort <= pcr_pkg::PORT_ONE;
        pcr_pkg::NODE_DUAL: begin
          reportPort <= (inPort == pcr_pkg::PORT_TWO) ?
                        pcr_pkg::PORT_TWO : pcr_pkg::PORT_ONE;
        end
        pcr_pkg::NODE_SWITCH: reportPort <= inPort;
        default: reportPort <= pcr_pkg::PORT_ONE;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- testbench/pcr_route_decoder_properties.sv
/*
  Checker of the route decoder outputs against its address bytes.
  Assumes it is bound to pcr_route_decoder and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_route_decoder_checker #(
  parameter int PORT_COUNT = 4
) (
  // clock, reset and inputs
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [1:0]  nodeKind,
  input wire logic [6:0]  inPort,
  input wire logic        frameStart,
  input wire logic        byteValid,
  input wire logic [7:0]  byteData,
  input wire logic        frameEnd,
  // results
  input wire logic        acceptValid,
  input wire logic [13:0] channelNum,
  input wire logic        forwardValid,
  input wire logic [6:0]  outPort,
  input wire logic [7:0]  hopByte,
  input wire logic        deleteHop,
  input wire logic        rejectValid,
  input wire logic        link_error_recovery,
  input wire logic [3:0]  recvErrorCode,
  input wire logic [6:0]  reportPort
);
  // ******************************
  // properties
  // ******************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic       first;
  logic [6:0] idx;
  logic       sw;
  // first path byte of a frame and its index
  assign first = frameStart && byteValid;
  assign idx = byteData[6:0];
  assign sw = first && nodeKind == 2'h2;
  sequence s_zero; first && byteData == 8'h00; endsequence
  sequence s_one; byteValid && !frameStart && !byteData[7]; endsequence
  sequence s_bad; byteValid && !frameStart && byteData == 8'h80; endsequence
  property p_code; rejectValid |-> link_error_recovery
    && recvErrorCode == pcr_pkg::CODE_FRAME_REJECT; endproperty
  a_code: assert property (p_code)
    else $error("reject without code");
  property p_cause; link_error_recovery |-> rejectValid; endproperty
  a_cause: assert property (p_cause)
    else $error("recovery without reject");
  property p_single; first && nodeKind == 2'h0 && byteData != 8'h00
    |=> rejectValid; endproperty
  a_single: assert property (p_single)
    else $error("single node kept nonzero path");
  property p_port1; $past(nodeKind) == 2'h0
    |-> reportPort == pcr_pkg::PORT_ONE; endproperty
  a_port1: assert property (p_port1)
    else $error("single node port not one");
  property p_dual_bad; first && nodeKind == 2'h1 && byteData == 8'h80
    |=> rejectValid; endproperty
  a_dual_bad: assert property (p_dual_bad)
    else $error("dual node kept 80h");
  property p_dual_fwd; first && nodeKind == 2'h1 && idx != 7'h00
    |=> forwardValid && !deleteHop && hopByte ==
    {$past(byteData[7]), 7'($past(byteData[6:0]) - 7'h01)}; endproperty
  a_dual_fwd: assert property (p_dual_fwd)
    else $error("dual forward wrong");
  property p_pair; sw && idx > PORT_COUNT |=> forwardValid && !deleteHop
    && outPort == ($past(inPort[0]) ? $past(inPort) + 7'h01
    : $past(inPort) - 7'h01) && hopByte == {$past(byteData[7]),
    7'($past(byteData[6:0]) - 7'(PORT_COUNT + 1))}; endproperty
  a_pair: assert property (p_pair)
    else $error("paired forward wrong");
  property p_direct; sw && byteData[7] && idx != 7'h00
    && idx <= PORT_COUNT && idx != inPort
    |=> forwardValid && deleteHop && outPort == $past(idx); endproperty
  a_direct: assert property (p_direct)
    else $error("direct forward wrong");
  property p_sw_rej; sw && byteData != 8'h00 && idx <= PORT_COUNT
    && (!byteData[7] || idx == inPort || idx == 7'h00)
    |=> rejectValid; endproperty
  a_sw_rej: assert property (p_sw_rej)
    else $error("switch kept bad path");
  property p_once;
    $onehot0({acceptValid, forwardValid, rejectValid}); endproperty
  a_once: assert property (p_once)
    else $error("two results at once");
  property p_chan; s_zero ##1 s_one |=> acceptValid
    && channelNum == {7'h00, $past(byteData[6:0])}; endproperty
  a_chan: assert property (p_chan)
    else $error("one byte channel wrong");
  property p_chan_bad; s_zero ##1 s_bad |=> rejectValid; endproperty
  a_chan_bad: assert property (p_chan_bad)
    else $error("channel 80h kept");
endmodule

bind pcr_route_decoder pcr_route_decoder_checker #(
  .PORT_COUNT(PORT_COUNT)) chk (.sys_clk(sys_clk), .resetn(resetn),
  .nodeKind(nodeKind), .inPort(inPort), .frameStart(frameStart),
  .byteValid(byteValid), .byteData(byteData), .frameEnd(frameEnd),
  .acceptValid(acceptValid), .channelNum(channelNum),
  .forwardValid(forwardValid), .outPort(outPort), .hopByte(hopByte),
  .deleteHop(deleteHop), .rejectValid(rejectValid),
  .link_error_recovery(link_error_recovery),
  .recvErrorCode(recvErrorCode), .reportPort(reportPort));
`default_nettype wire

//--- testbench/pcr_port_rx_model.sv
/*
  Model of the port receiver: sends the address bytes of one frame.
  Assumes go is a one-cycle request taken only while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_port_rx_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // frame request, first byte in the top bits
  input  wire logic        go,
  input  wire logic [1:0]  len,
  input  wire logic [23:0] bytes,
  // byte stream
  output logic             frameStart,
  output logic             byteValid,
  output logic [7:0]       byteData,
  output logic             frameEnd,
  output logic             busy
);
  logic [23:0] shiftReg;
  logic [1:0]  leftReg;
  logic        firstReg;
  // ******************************
  // one byte a cycle, then end mark
  // ******************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {frameStart, byteValid, frameEnd, busy, firstReg} <= 5'h00;
      byteData <= 8'h00;
      shiftReg <= 24'h000000;
      leftReg <= 2'h0;
    end else begin
      frameStart <= 1'b0;
      byteValid <= 1'b0;
      frameEnd <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        shiftReg <= bytes;
        leftReg <= len;
        firstReg <= 1'b1;
      end else if (busy && leftReg != 2'h0) begin
        byteValid <= 1'b1;
        frameStart <= firstReg;
        byteData <= shiftReg[23:16]; // flag in bit 7
        shiftReg <= shiftReg << 8;
        leftReg <= leftReg - 2'h1;
        firstReg <= 1'b0;
      end else begin
        byteData <= ~byteData; // stale data never looks held
        frameEnd <= busy;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/pcr_route_decoder_test.sv
/*
  Self-checking bench of the route decoder with a receiver model.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_route_decoder_test;
  localparam int PORTS = 6;
  logic        sys_clk, resetn, go, busy;
  logic        frameStart, byteValid, frameEnd;
  logic [1:0]  nodeKind, len;
  logic [6:0]  inPort, outPort, reportPort;
  logic [23:0] bytes;
  logic [7:0]  byteData, hopByte;
  logic [13:0] channelNum;
  logic [3:0]  recvErrorCode;
  logic        acceptValid, forwardValid, deleteHop;
  logic        rejectValid, link_error_recovery;
  int          errors, nTests;

  pcr_route_decoder #(.PORT_COUNT(PORTS)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .nodeKind(nodeKind), .inPort(inPort),
    .frameStart(frameStart), .byteValid(byteValid),
    .byteData(byteData), .frameEnd(frameEnd),
    .acceptValid(acceptValid), .channelNum(channelNum),
    .forwardValid(forwardValid), .outPort(outPort), .hopByte(hopByte),
    .deleteHop(deleteHop), .rejectValid(rejectValid),
    .link_error_recovery(link_error_recovery),
    .recvErrorCode(recvErrorCode), .reportPort(reportPort));
  pcr_port_rx_model rx (.sys_clk(sys_clk), .resetn(resetn), .go(go),
    .len(len), .bytes(bytes), .frameStart(frameStart),
    .byteValid(byteValid), .byteData(byteData), .frameEnd(frameEnd),
    .busy(busy));

  // ******************************
  // clock, checks and expectations
  // ******************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // result, port, hop byte, delete, channel packed into one word
  function automatic logic [31:0] expect_of(input logic [1:0] k,
      input logic [6:0] ip, input logic [1:0] n, input logic [23:0] b);
    logic [7:0]  p, c1, c2, h;
    logic [13:0] v;
    logic [1:0]  r;
    logic [6:0]  o;
    logic        d;
    {p, c1, c2} = b;
    {r, o, h, d} = {2'h2, 7'h00, 8'h00, 1'b0};
    v = {c1[6:0], c2[6:0]};
    // the unused node code refuses every first byte, 00h included
    if (p == 8'h00 && k != 2'h3) begin
      if (n >= 2'h2 && c1 != 8'h80 && !c1[7]) begin
        r = 2'h0;
        v = {7'h00, c1[6:0]};
      end else if (n == 2'h3 && c1[7] && !c2[7])
        r = (v >= pcr_pkg::CHAN_TWO_MIN) ? 2'h0 : 2'h2;
    end else if (k == 2'h1 && p[6:0] != 7'h00) begin
      {r, o, h} = {2'h1, (ip == 7'h01) ? 7'h02 : 7'h01, p - 8'h01};
    end else if (k == 2'h2 && p[6:0] > PORTS) begin
      o = ip[0] ? ip + 7'h01 : ip - 7'h01;
      {r, h} = {2'h1, p[7], 7'(p[6:0] - 7'(PORTS + 1))};
    end else if (k == 2'h2 && p[7] && p[6:0] != ip && p != 8'h80)
      {r, o, d} = {2'h1, p[6:0], 1'b1};
    return {r, o, h, d, v};
  endfunction

  task automatic run(input logic [1:0] k, input logic [6:0] ip,
                     input logic [1:0] n, input logic [23:0] b);
    logic [31:0] e;
    logic [1:0]  r;
    int          i;
    e = expect_of(k, ip, n, b);
    @(posedge sys_clk);
    nodeKind <= k;
    inPort <= ip;
    len <= n;
    bytes <= b;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    r = 2'h3;
    for (i = 0; i < 12 && r == 2'h3; i++) begin
      @(posedge sys_clk);
      #1;
      r = acceptValid ? 2'h0 : forwardValid ? 2'h1 : rejectValid ? 2'h2
        : 2'h3;
    end
    check("outcome", r, e[31:30]);
    if (r == 2'h3) tally_and_finish;
    if (r == 2'h0) check("channel", channelNum, e[13:0]);
    if (r == 2'h1) check("port", outPort, e[29:23]);
    if (r == 2'h1) check("delete", deleteHop, e[14]);
    if (r == 2'h1 && !e[14]) check("hop", hopByte, e[22:15]);
    if (r == 2'h2) check("code", recvErrorCode, pcr_pkg::CODE_FRAME_REJECT);
    if (r == 2'h2) check("erp", link_error_recovery, 1'b1);
    check("report", reportPort, k[0] == k[1] ? 7'h01 : ip);
    for (i = 0; i < 8 && busy; i++) @(posedge sys_clk);
    check("idle", busy, 1'b0);
    if (busy) tally_and_finish;
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    logic [1:0]  k;
    logic [6:0]  ip;
    logic [23:0] b;
    {errors, nTests} = {32'h0, 32'h0};
    {resetn, go, nodeKind, len, bytes} = 30'h0;
    inPort = 7'h01;
    void'($urandom(93248));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    run(2'h0, 7'h01, 2'h2, 24'h000500);
    run(2'h0, 7'h01, 2'h1, 24'h010000);
    run(2'h1, 7'h01, 2'h1, 24'h850000);
    run(2'h1, 7'h02, 2'h1, 24'h030000);
    run(2'h1, 7'h02, 2'h1, 24'h800000);
    run(2'h2, 7'h01, 2'h1, 24'h830000);
    run(2'h2, 7'h01, 2'h1, 24'h860000);
    run(2'h2, 7'h01, 2'h1, 24'h070000);
    run(2'h2, 7'h04, 2'h1, 24'h870000);
    run(2'h2, 7'h05, 2'h1, 24'hc60000);
    run(2'h2, 7'h02, 2'h1, 24'h820000);
    run(2'h2, 7'h01, 2'h1, 24'h060000);
    run(2'h2, 7'h01, 2'h1, 24'h800000);
    run(2'h2, 7'h03, 2'h3, 24'h008105);
    run(2'h2, 7'h03, 2'h3, 24'h008100);
    run(2'h0, 7'h01, 2'h3, 24'h00ff7f);
    run(2'h0, 7'h01, 2'h2, 24'h008000);
    run(2'h1, 7'h01, 2'h2, 24'h008100);
    run(2'h0, 7'h01, 2'h3, 24'h008185);
    run(2'h3, 7'h02, 2'h1, 24'h000000);
    $display("test corners done");
    for (int j = 0; j < 150; j++) begin
      k = 2'($urandom_range(2, 0));
      ip = k == 2'h2 ? 7'($urandom_range(PORTS, 1))
         : k == 2'h1 ? 7'($urandom_range(2, 1)) : 7'h01;
      b = 24'($urandom);
      if ($urandom_range(3, 0) == 0) b[23:16] = 8'h00;
      run(k, ip, 2'($urandom_range(3, 1)), b);
    end
    $display("test random done");
    run(2'h0, 7'h01, 2'h1, 24'h010000);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("reset code", recvErrorCode, pcr_pkg::CODE_NONE);
    check("reset port", reportPort, pcr_pkg::PORT_ONE);
    @(posedge sys_clk);
    resetn <= 1'b1;
    // the decoder must route again right after the release
    run(2'h2, 7'h01, 2'h1, 24'h830000);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
